// >>> common/ccpd_map.vh
// Constants of the clock and power-down controller: offsets, fields, resets, counts.
// Assumes a 9-bit Wishbone byte address and 32-bit data.
// How it works
// - No power-down until the enable bit is set and, with the wait bit set, the processor sleeps.
// - Power-down switches off the high-speed crystal and the high-speed oscillator.
// - Power-down lasts until the wake-up request fires, whatever the wake-up enable bit, then ends.
// - Five sources: low and high crystal, PLL, high and low oscillator.
// - PLL reference picks the high-speed crystal or the high-speed oscillator.
// - System clock source comes from select field A bits 2 to 0.
// - External tick clock source comes from select field A bits 5 to 3.
// - Low-speed sources keep running in power-down; watchdog and RTC follow them.
// - Protected bits change only after unlock bytes 59h, 16h, 88h.
// - Wait bit set needs processor sleep; clear enters at once.
// - Each peripheral clock has its own gate; system and tick clocks have a source select, only the system clock a divider.
// - Waking clears the power-down enable bit.
// - Optional wake delay: 4096 cycles on the high-speed crystal, 256 on any other source.
// - PLL and system clock are off in power-down whatever the selection.
`ifndef CCPD_MAP_VH
`define CCPD_MAP_VH
`define CCPD_OFS_PWR 9'h000
`define CCPD_OFS_AHB 9'h004
`define CCPD_OFS_APB 9'h008
`define CCPD_OFS_STS 9'h00C
`define CCPD_OFS_SELA 9'h010
`define CCPD_OFS_SELB 9'h014
`define CCPD_OFS_DIV 9'h018
`define CCPD_OFS_PLL 9'h020
`define CCPD_OFS_WP 9'h100
`define CCPD_RST_PWR 32'h0000_001C
`define CCPD_RST_AHB 32'h0000_000D
`define CCPD_RST_APB 32'h0000_0000
`define CCPD_RST_SELA 32'h0000_003F
`define CCPD_RST_SELB 32'hFFFF_FFFF
`define CCPD_RST_DIV 32'h0000_0000
`define CCPD_RST_PLL 32'h0005_C22E
`define CCPD_B_HXT 0
`define CCPD_B_LXT 1
`define CCPD_B_HIRC 2
`define CCPD_B_LIRC 3
`define CCPD_B_DLY 4
`define CCPD_B_WIE 5
`define CCPD_B_WST 6
`define CCPD_B_PDEN 7
`define CCPD_B_WAIT 8
`define CCPD_B_PLL_OFF 16
`define CCPD_B_PLL_REF 19
`define CCPD_B_WDT 0
`define CCPD_B_RTC 1
`define CCPD_KEY0 8'h59
`define CCPD_KEY1 8'h16
`define CCPD_KEY2 8'h88
`define CCPD_SRC_HXT 3'h0
`define CCPD_SRC_LXT 3'h1
`define CCPD_SRC_PLL 3'h2
`define CCPD_SRC_LIRC 3'h3
`define CCPD_SRC_HIRC 3'h7
`define CCPD_WDT_LIRC 2'h3
`define CCPD_DLY_HXT 4096
`define CCPD_DLY_HIRC 256
`define CCPD_SW_GAP 4
`endif

// >>> design/ccpd_top.v
// Clock and power-down controller: registers, source selection, gating, sleep.
// Assumes a classic Wishbone master on clk_i and analog clock cells outside.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/10ps
`include "ccpd_map.vh"
module ccpd_top #(
    parameter HXT_DLY = `CCPD_DLY_HXT,
    parameter HIRC_DLY = `CCPD_DLY_HIRC,
    parameter SW_GAP = `CCPD_SW_GAP
)(
    input wire clk_i,
    input wire rst_i,
    input wire [8:0] adr_i,
    input wire [31:0] dat_i,
    input wire [3:0] sel_i,
    input wire we_i,
    input wire cyc_i,
    input wire stb_i,
    output reg [31:0] dat_o,
    output wire ack_o,
    input wire cpu_asleep_i,
    input wire wake_irq_i,
    input wire [4:0] src_stable_i,
    input wire tick_use_ext_i,
    output reg xtl_hs_en_o,
    output reg xtl_ls_en_o,
    output reg hirc_en_o,
    output reg lirc_en_o,
    output reg pll_en_o,
    output reg pll_ref_hirc_o,
    output reg [4:0] sys_src_en_o,
    output reg [4:0] tick_src_en_o,
    output reg [31:0] ahb_clk_en_o,
    output reg [31:0] apb_clk_en_o,
    output reg hclk_tick_o,
    output reg pd_active_o
);
    localparam ST_RUN = 2'd0;
    localparam ST_PD = 2'd1;
    localparam ST_DLY = 2'd2;

    // Maps a three-bit source code onto one enable per source.
    function [4:0] ccpd_onehot;
        input [2:0] code;
        begin
            case (code)
                `CCPD_SRC_HXT: ccpd_onehot = 5'h01;
                `CCPD_SRC_LXT: ccpd_onehot = 5'h02;
                `CCPD_SRC_PLL: ccpd_onehot = 5'h04;
                `CCPD_SRC_LIRC: ccpd_onehot = 5'h08;
                `CCPD_SRC_HIRC: ccpd_onehot = 5'h10;
                default: ccpd_onehot = 5'h00;
            endcase
        end
    endfunction

    // Merges written bytes into an old word under the byte enables.
    function [31:0] ccpd_merge;
        input [31:0] old;
        input [31:0] val;
        input [3:0] lanes;
        integer i;
        begin
            ccpd_merge = old;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (lanes[i])
                    ccpd_merge[i*8 +: 8] = val[i*8 +: 8];
            end
        end
    endfunction

    reg ack_ff;
    reg [31:0] pwr_ff;
    reg [31:0] ahb_ff;
    reg [31:0] apb_ff;
    reg [31:0] sela_ff;
    reg [31:0] selb_ff;
    reg [31:0] div_ff;
    reg [31:0] pll_ff;
    reg [1:0] key_ff;
    reg unlock_ff;
    reg [1:0] st_ff;
    reg [12:0] dly_ff;
    reg [3:0] hdiv_ff;
    reg wake_m_ff;
    reg wake_s_ff;
    reg [4:0] stb_m_ff;
    reg [4:0] stb_s_ff;
    reg [31:0] nxt_pwr;
    reg [31:0] rd_data;
    wire req;
    wire wr;
    wire [31:0] wval;
    wire pd_go;
    wire wake_ev;
    wire in_pd;
    wire hold;

    assign req = cyc_i & stb_i & ~ack_ff;
    assign wr = req & we_i;
    assign ack_o = ack_ff;
    assign in_pd = (st_ff == ST_PD);
    assign hold = (st_ff != ST_RUN);
    assign wake_ev = in_pd & wake_s_ff;
    // Entry waits for the processor only when the wait bit is set.
    assign pd_go = pwr_ff[`CCPD_B_PDEN] & (~pwr_ff[`CCPD_B_WAIT] | cpu_asleep_i);

    // Wake request and stable flags come from other domains.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wake_m_ff <= 1'b0;
            wake_s_ff <= 1'b0;
            stb_m_ff <= 5'h00;
            stb_s_ff <= 5'h00;
        end
        else
        begin
            wake_m_ff <= wake_irq_i;
            wake_s_ff <= wake_m_ff;
            stb_m_ff <= src_stable_i;
            stb_s_ff <= stb_m_ff;
        end
    end

    always @*
    begin
        case (adr_i)
            `CCPD_OFS_PWR: rd_data = {23'h0, pwr_ff[8:0]};
            `CCPD_OFS_AHB: rd_data = ahb_ff;
            `CCPD_OFS_APB: rd_data = apb_ff;
            `CCPD_OFS_STS: rd_data = {27'h0, stb_s_ff};
            `CCPD_OFS_SELA: rd_data = sela_ff;
            `CCPD_OFS_SELB: rd_data = selb_ff;
            `CCPD_OFS_DIV: rd_data = div_ff;
            `CCPD_OFS_PLL: rd_data = pll_ff;
            `CCPD_OFS_WP: rd_data = {31'h0, unlock_ff};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    assign wval = ccpd_merge(pwr_ff, dat_i, sel_i);

    // Power-down control word after a write and the hardware events.
    always @*
    begin
        nxt_pwr = pwr_ff;
        if (wr && adr_i == `CCPD_OFS_PWR)
        begin
            if (unlock_ff)
                nxt_pwr = {23'h0, wval[8:7], pwr_ff[6], wval[5:0]};
            if (sel_i[0] && dat_i[`CCPD_B_WST])
                nxt_pwr[`CCPD_B_WST] = 1'b0;
        end
        if (wake_ev)
        begin
            nxt_pwr[`CCPD_B_PDEN] = 1'b0;
            nxt_pwr[`CCPD_B_WST] = 1'b1;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            dat_o <= 32'h0000_0000;
            pwr_ff <= `CCPD_RST_PWR;
            ahb_ff <= `CCPD_RST_AHB;
            apb_ff <= `CCPD_RST_APB;
            sela_ff <= `CCPD_RST_SELA;
            selb_ff <= `CCPD_RST_SELB;
            div_ff <= `CCPD_RST_DIV;
            pll_ff <= `CCPD_RST_PLL;
            key_ff <= 2'd0;
            unlock_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= req;
            if (req)
                dat_o <= rd_data;
            pwr_ff <= nxt_pwr;
            if (wr)
            begin
                case (adr_i)
                    `CCPD_OFS_AHB: ahb_ff <= ccpd_merge(ahb_ff, dat_i, sel_i);
                    `CCPD_OFS_APB:
                    begin
                        apb_ff <= ccpd_merge(apb_ff, dat_i, sel_i);
                        if (!unlock_ff)
                            apb_ff[`CCPD_B_WDT] <= apb_ff[`CCPD_B_WDT];
                    end
                    `CCPD_OFS_SELA: sela_ff <= ccpd_merge(sela_ff, dat_i, sel_i);
                    `CCPD_OFS_SELB: selb_ff <= ccpd_merge(selb_ff, dat_i, sel_i);
                    `CCPD_OFS_DIV: div_ff <= ccpd_merge(div_ff, dat_i, sel_i);
                    `CCPD_OFS_PLL: pll_ff <= ccpd_merge(pll_ff, dat_i, sel_i);
                    `CCPD_OFS_WP:
                    begin
                        // Any byte out of sequence restarts it and locks again.
                        unlock_ff <= 1'b0;
                        key_ff <= 2'd0;
                        if (key_ff == 2'd0 && dat_i[7:0] == `CCPD_KEY0)
                            key_ff <= 2'd1;
                        else if (key_ff == 2'd1 && dat_i[7:0] == `CCPD_KEY1)
                            key_ff <= 2'd2;
                        else if (key_ff == 2'd2 && dat_i[7:0] == `CCPD_KEY2)
                            unlock_ff <= 1'b1;
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    // Power state and wake delay counter.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= ST_RUN;
            dly_ff <= 13'h0000;
        end
        else
        begin
            case (st_ff)
                ST_RUN:
                    if (pd_go)
                        st_ff <= ST_PD;
                ST_PD:
                    if (wake_ev)
                    begin
                        if (pwr_ff[`CCPD_B_DLY])
                        begin
                            st_ff <= ST_DLY;
                            if (sela_ff[2:0] == `CCPD_SRC_HXT)
                                dly_ff <= HXT_DLY[12:0] - 13'h0001;
                            else
                                dly_ff <= HIRC_DLY[12:0] - 13'h0001;
                        end
                        else
                            st_ff <= ST_RUN;
                    end
                ST_DLY:
                    if (dly_ff == 13'h0000)
                        st_ff <= ST_RUN;
                    else
                        dly_ff <= dly_ff - 13'h0001;
                default: st_ff <= ST_RUN;
            endcase
        end
    end

    // Break-before-make switchers: one for the system clock, one for the tick clock.
    genvar k;
    generate
        for (k = 0; k < 2; k = k + 1)
        begin : sw_g
            reg [4:0] cur_ff;
            reg [3:0] gap_ff;
            wire [4:0] want;
            assign want = ccpd_onehot(sela_ff[k*3 +: 3]);
            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    cur_ff <= 5'h00;
                    gap_ff <= SW_GAP[3:0];
                end
                else if (cur_ff != 5'h00 && cur_ff != want)
                begin
                    cur_ff <= 5'h00;
                    gap_ff <= SW_GAP[3:0];
                end
                else if (cur_ff == 5'h00)
                begin
                    if (gap_ff != 4'h0)
                        gap_ff <= gap_ff - 4'h1;
                    else
                        cur_ff <= want;
                end
            end
        end
    endgenerate

    // Registered clock enables towards the clock cells and consumers.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            xtl_hs_en_o <= 1'b0;
            xtl_ls_en_o <= 1'b0;
            hirc_en_o <= 1'b0;
            lirc_en_o <= 1'b0;
            pll_en_o <= 1'b0;
            pll_ref_hirc_o <= 1'b0;
            sys_src_en_o <= 5'h00;
            tick_src_en_o <= 5'h00;
            ahb_clk_en_o <= 32'h0000_0000;
            apb_clk_en_o <= 32'h0000_0000;
            pd_active_o <= 1'b0;
        end
        else
        begin
            xtl_hs_en_o <= pwr_ff[`CCPD_B_HXT] & ~in_pd;
            hirc_en_o <= pwr_ff[`CCPD_B_HIRC] & ~in_pd;
            xtl_ls_en_o <= pwr_ff[`CCPD_B_LXT];
            lirc_en_o <= pwr_ff[`CCPD_B_LIRC];
            pll_en_o <= ~pll_ff[`CCPD_B_PLL_OFF] & ~in_pd;
            pll_ref_hirc_o <= pll_ff[`CCPD_B_PLL_REF];
            sys_src_en_o <= hold ? 5'h00 : sw_g[0].cur_ff;
            tick_src_en_o <= (hold | ~tick_use_ext_i) ? 5'h00 : sw_g[1].cur_ff;
            ahb_clk_en_o <= hold ? 32'h0000_0000 : ahb_ff;
            apb_clk_en_o <= hold ? 32'h0000_0000 : apb_ff;
            if (hold)
            begin
                // Watchdog and RTC stay clocked when fed from low-speed sources.
                apb_clk_en_o[`CCPD_B_WDT] <= apb_ff[`CCPD_B_WDT] & pwr_ff[`CCPD_B_LIRC]
                    & (selb_ff[1:0] == `CCPD_WDT_LIRC);
                apb_clk_en_o[`CCPD_B_RTC] <= apb_ff[`CCPD_B_RTC] & pwr_ff[`CCPD_B_LXT];
            end
            pd_active_o <= in_pd;
        end
    end

    // System clock divider: one-cycle enable every divider field plus one cycles.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hdiv_ff <= 4'h0;
            hclk_tick_o <= 1'b0;
        end
        else if (hold)
        begin
            hdiv_ff <= 4'h0;
            hclk_tick_o <= 1'b0;
        end
        else if (hdiv_ff >= div_ff[3:0])
        begin
            hdiv_ff <= 4'h0;
            hclk_tick_o <= 1'b1;
        end
        else
        begin
            hdiv_ff <= hdiv_ff + 4'h1;
            hclk_tick_o <= 1'b0;
        end
    end
endmodule

// >>> test/ccpd_far.sv
// Far-side model: processor sleep flag, wake-up source and oscillator cells.
// Assumes the bench commands sleep and wake; flags settle one cycle after enable.
`timescale 1ns/10ps
module ccpd_far (
    input wire clk_i,
    input wire rst_i,
    input wire sleep_i,
    input wire wake_i,
    input wire [4:0] osc_en_i,
    output reg cpu_asleep_o = 1'b0,
    output reg wake_irq_o = 1'b0,
    output reg [4:0] src_stable_o = 5'h00
);
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        cpu_asleep_o <= 1'b0;
        wake_irq_o <= 1'b0;
        src_stable_o <= 5'h00;
    end
    else
    begin
        // The processor leaves its sleep as soon as the wake-up source fires.
        cpu_asleep_o <= sleep_i & ~wake_i;
        wake_irq_o <= wake_i;
        src_stable_o <= osc_en_i;
    end
end
endmodule

// >>> test/ccpd_top_asserts.sv
// Port checker for the clock and power-down controller.
// Assumes one clock domain and a bind onto ccpd_top.
`timescale 1ns/10ps
module ccpd_chk #(
    parameter HXT_DLY = 4096,
    parameter HIRC_DLY = 256,
    parameter SW_GAP = 4
)(
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire ack_o,
    input wire wake_irq_i,
    input wire tick_use_ext_i,
    input wire xtl_hs_en_o,
    input wire xtl_ls_en_o,
    input wire hirc_en_o,
    input wire lirc_en_o,
    input wire pll_en_o,
    input wire [4:0] sys_src_en_o,
    input wire [4:0] tick_src_en_o,
    input wire [31:0] ahb_clk_en_o,
    input wire [31:0] apb_clk_en_o,
    input wire pd_active_o
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
sequence s_pd_held;
    pd_active_o && $past(pd_active_o);
endsequence
sequence s_wake_held;
    wake_irq_i [*3];
endsequence
a_hs_off_pd: assert property (s_pd_held |-> !xtl_hs_en_o && !hirc_en_o)
    else $error("High-speed source on in power-down.");
a_pll_off_pd: assert property (s_pd_held |-> !pll_en_o && sys_src_en_o == 5'h00)
    else $error("System clock or PLL on in power-down.");
a_gates_pd: assert property (s_pd_held |-> ahb_clk_en_o == 32'h0 && apb_clk_en_o[31:2] == 30'h0)
    else $error("Peripheral gate open in power-down.");
a_low_kept: assert property ($rose(pd_active_o) |-> $stable(xtl_ls_en_o) && $stable(lirc_en_o))
    else $error("Low-speed source changed on power-down entry.");
a_wake_exit: assert property (s_wake_held ##0 pd_active_o |-> ##[0:4] !pd_active_o)
    else $error("No exit from power-down after wake-up.");
a_stay_pd: assert property (pd_active_o && !wake_irq_i && !$past(wake_irq_i) && !$past(wake_irq_i, 2)
    && !$past(wake_irq_i, 3) && !$past(wake_irq_i, 4) |=> pd_active_o)
    else $error("Power-down left without wake-up.");
a_src_onehot: assert property ($onehot0(sys_src_en_o) && $onehot0(tick_src_en_o))
    else $error("More than one source enabled.");
a_no_overlap: assert property (sys_src_en_o != 5'h00 && $past(sys_src_en_o) != 5'h00
    |-> sys_src_en_o == $past(sys_src_en_o))
    else $error("Source switched without a gap.");
a_tick_gate: assert property (!tick_use_ext_i [*2] |-> tick_src_en_o == 5'h00)
    else $error("External tick source on while unused.");
a_ack_once: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("Register access not acknowledged once.");
endmodule
bind ccpd_top ccpd_chk #(.HXT_DLY(HXT_DLY), .HIRC_DLY(HIRC_DLY), .SW_GAP(SW_GAP)) ccpd_chk_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .wake_irq_i(wake_irq_i),
    .tick_use_ext_i(tick_use_ext_i), .xtl_hs_en_o(xtl_hs_en_o), .xtl_ls_en_o(xtl_ls_en_o),
    .hirc_en_o(hirc_en_o), .lirc_en_o(lirc_en_o), .pll_en_o(pll_en_o), .sys_src_en_o(sys_src_en_o),
    .tick_src_en_o(tick_src_en_o), .ahb_clk_en_o(ahb_clk_en_o), .apb_clk_en_o(apb_clk_en_o),
    .pd_active_o(pd_active_o));

// >>> test/ccpd_top_tb.sv
// Self-checking bench for the clock and power-down controller.
// Assumes the far-side model ccpd_far and a Wishbone master in this module.
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
    $display("ERROR %0t got %h expected %h", $time, a, e); end end
module ccpd_top_tb;
localparam HD = 40;
localparam ID = 20;
localparam GAP = 4;
logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, sleep = 0, wake = 0, use_ext = 0;
logic [8:0] adr_i = 9'h000;
logic [31:0] dat_i = 32'h0000_0000, rv, dat_o, ahb_o, apb_o;
logic ack_o, asleep, wirq, hs, ls, hirc, lirc, pll, pref, tick, pd;
logic [4:0] stab, sys, tsrc;
int n_mismatch = 0, tests_run = 0;
always #20 clk_i = ~clk_i;
ccpd_top #(.HXT_DLY(HD), .HIRC_DLY(ID), .SW_GAP(GAP)) ccpd_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(4'hF), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
    .ack_o(ack_o), .cpu_asleep_i(asleep), .wake_irq_i(wirq), .src_stable_i(stab), .tick_use_ext_i(use_ext),
    .xtl_hs_en_o(hs), .xtl_ls_en_o(ls), .hirc_en_o(hirc), .lirc_en_o(lirc), .pll_en_o(pll),
    .pll_ref_hirc_o(pref), .sys_src_en_o(sys), .tick_src_en_o(tsrc), .ahb_clk_en_o(ahb_o),
    .apb_clk_en_o(apb_o), .hclk_tick_o(tick), .pd_active_o(pd));
ccpd_far ccpd_far_inst (.clk_i(clk_i), .rst_i(rst_i), .sleep_i(sleep), .wake_i(wake),
    .osc_en_i({hirc, lirc, pll, ls, hs}), .cpu_asleep_o(asleep), .wake_irq_o(wirq), .src_stable_o(stab));
task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rv = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
endtask
task automatic unlock;
    wb(1, 9'h100, 32'h0000_0059);
    wb(1, 9'h100, 32'h0000_0016);
    wb(1, 9'h100, 32'h0000_0088);
endtask
task automatic t_reset;
    logic [8:0] a [9] = '{9'h000, 9'h004, 9'h008, 9'h010, 9'h014, 9'h018, 9'h020, 9'h1FC, 9'h00C};
    logic [31:0] e [9] = '{32'h1C, 32'hD, 32'h0, 32'h3F, 32'hFFFF_FFFF, 32'h0, 32'h5_C22E, 32'h0, 32'h18};
    for (int i = 0; i < 9; i++)
    begin
        wb(0, a[i], 32'h0);
        `CHK(rv, e[i])
    end
endtask
task automatic t_protect;
    wb(1, 9'h000, 32'h0);
    wb(0, 9'h000, 32'h0);
    `CHK(rv, 32'h0000_001C)
    wb(1, 9'h100, 32'h16);
    wb(1, 9'h100, 32'h59);
    wb(1, 9'h100, 32'h88);
    wb(0, 9'h100, 32'h0);
    `CHK(rv[0], 1'b0)
    unlock;
    wb(0, 9'h100, 32'h0);
    `CHK(rv[0], 1'b1)
    wb(1, 9'h008, 32'h3);
    wb(1, 9'h100, 32'h0);
    wb(1, 9'h008, 32'h0);
    wb(0, 9'h008, 32'h0);
    `CHK(rv, 32'h0000_0001)
endtask
task automatic t_sources;
    logic [2:0] c [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
    logic [4:0] o [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00};
    unlock;
    wb(1, 9'h000, 32'h0F);
    wb(1, 9'h020, 32'h0);
    `CHK({hs, ls, hirc, lirc, pll, pref}, 6'h3E)
    wb(1, 9'h020, 32'h0008_0000);
    `CHK({pll, pref}, 2'h3)
    use_ext <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
        wb(1, 9'h010, {26'h0, c[5-i], c[i]});
        repeat (GAP + 4) @(posedge clk_i);
        `CHK(sys, o[i])
        `CHK(tsrc, o[5-i])
    end
    use_ext <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(tsrc, 5'h00)
endtask
task automatic t_pd_wait;
    wb(1, 9'h010, 32'h07);
    wb(1, 9'h008, 32'h3);
    wb(1, 9'h000, 32'h18F);
    repeat (10) @(posedge clk_i);
    `CHK(pd, 1'b0)
    sleep <= 1'b1;
    repeat (4) @(posedge clk_i);
    `CHK(pd, 1'b1)
    `CHK({hs, hirc, pll, sys}, 8'h00)
    `CHK({ls, lirc, apb_o, ahb_o}, {2'h3, 32'h3, 32'h0})
    repeat (20) @(posedge clk_i);
    `CHK(pd, 1'b1)
    wake <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK(pd, 1'b0)
    wake <= 1'b0;
    sleep <= 1'b0;
    wb(0, 9'h000, 32'h0);
    `CHK(rv, 32'h0000_014F)
    // Bit 6 is write-one-to-clear, so writing it back as one clears the wake status.
    wb(1, 9'h000, 32'h14F);
    wb(0, 9'h000, 32'h0);
    `CHK(rv, 32'h0000_010F)
endtask
task automatic t_pd_now;
    logic [2:0] c [2] = '{3'h7, 3'h0};
    int d [2] = '{ID, HD};
    int n;
    for (int i = 0; i < 2; i++)
    begin
        wb(1, 9'h010, {29'h0, c[i]});
        repeat (GAP + 4) @(posedge clk_i);
        wb(1, 9'h000, 32'h09F);
        repeat (4) @(posedge clk_i);
        `CHK(pd, 1'b1)
        wake <= 1'b1;
        n = 0;
        while (pd !== 1'b0 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        wake <= 1'b0;
        n = 0;
        while (sys === 5'h00 && n < 200)
        begin
            @(posedge clk_i);
            n++;
        end
        `CHK(n >= d[i] - 2 && n <= d[i] + 8, 1'b1)
    end
endtask
task automatic t_div;
    int n = 0;
    wb(1, 9'h018, 32'h3);
    repeat (4) @(posedge clk_i);
    `CHK({ahb_o, apb_o}, {32'h0000_000D, 32'h0000_0003})
    repeat (40)
    begin
        @(posedge clk_i);
        if (tick === 1'b1) n++;
    end
    `CHK(n, 10)
endtask
task automatic summarize;
    $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask
initial
begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_protect;
    t_sources;
    t_pd_wait;
    t_pd_now;
    t_div;
    summarize;
end
initial
begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    summarize;
end
endmodule
